// ===== core/fpcc_blink_timer.v
// Shared blink phase and power-up sweep step generator.
// Assumes one free-running system clock with a clock enable.
`timescale 1ns/1ps
`include "fpcc_map.vh"
module fpcc_blink_timer (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    output reg o_phase,
    output reg o_step
);
    reg [23:0] blink_cnt;
    reg [23:0] step_cnt;
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            blink_cnt <= 24'h00_0000;
            step_cnt <= 24'h00_0000;
            o_phase <= 1'b0;
            o_step <= 1'b0;
        end else if (i_ce) begin
            o_step <= 1'b0;
            if (blink_cnt == `FPCC_BLINK_HALF_CYC - 1) begin
                blink_cnt <= 24'h00_0000;
                o_phase <= ~o_phase;
            end else begin
                blink_cnt <= blink_cnt + 24'h00_0001;
            end
            if (step_cnt == `FPCC_SWEEP_STEP_CYC - 1) begin
                step_cnt <= 24'h00_0000;
                o_step <= 1'b1;
            end else begin
                step_cnt <= step_cnt + 24'h00_0001;
            end
        end
    end
endmodule // fpcc_blink_timer

// ===== core/fpcc_console.v
// Front-panel console: key decoding, mode control, lamps and displays.
// Assumes synchronous debounced keys and status from the controller core.
`timescale 1ns/1ps
`include "fpcc_map.vh"
module fpcc_console (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_view_key,
    input wire i_pattern_key,
    input wire i_go_pause_key,
    input wire i_shift_key,
    input wire i_commit_key,
    input wire i_erase_key,
    input wire i_param_key,
    input wire i_down_key,
    input wire i_auto_manual_key,
    input wire i_program_end,
    input wire i_constant_mode,
    input wire i_alarm,
    input wire [7:0] i_alarm_code,
    input wire [7:0] i_segment,
    input wire [7:0] i_item_number,
    input wire [7:0] i_edit_segment,
    input wire i_battery_low,
    input wire i_auto_tuning,
    input wire i_smart_tuning,
    input wire [1:0] i_out1_kind,
    input wire [1:0] i_out2_kind,
    input wire i_position_prop,
    input wire i_out1_on,
    input wire i_out2_on,
    input wire i_open_relay_on,
    input wire i_close_relay_on,
    input wire [2:0] i_events,
    input wire [4:0] i_time_events,
    input wire [2:0] i_event_item_shown,
    input wire [4:0] i_time_item_shown,
    input wire [1:0] i_trend,
    input wire i_soak_standby,
    input wire i_setup_exit,
    output reg [2:0] o_mode,
    output reg [2:0] o_console_state,
    output reg o_manual,
    output reg o_advance,
    output reg o_seg_insert_delete,
    output reg o_item_clear,
    output reg o_run_lamp,
    output reg o_hold_lamp,
    output reg o_hand_control_lamp,
    output reg o_programming_lamp,
    output reg o_low_cell_lamp,
    output reg o_tuning_lamp,
    output reg o_drive1_lamp,
    output reg o_drive2_lamp,
    output reg o_measured_value_lamp,
    output reg o_setpoint_lamp,
    output reg o_output_lamp,
    output reg o_timer_lamp,
    output reg o_period_lamp,
    output reg o_channel_one_lamp,
    output reg o_channel_two_lamp,
    output reg [2:0] o_occurrence_lamps,
    output reg [4:0] o_timed_signal_lamps,
    output reg [7:0] o_program_display,
    output reg [7:0] o_segment_display,
    output reg [`FPCC_PROFILE_W-1:0] o_profile
);
    // ----------------------------------------
    // Key edges
    // ----------------------------------------
    wire [8:0] keys = {i_auto_manual_key, i_down_key, i_param_key, i_erase_key, i_commit_key,
                       i_shift_key, i_go_pause_key, i_pattern_key, i_view_key};
    wire [8:0] press;
    genvar g;
    generate
        for (g = 0; g < 9; g = g + 1) begin : g_edge
            fpcc_key_edge u_edge (
                .i_sys_clk(i_sys_clk),
                .i_rstn(i_rstn),
                .i_ce(i_ce),
                .i_key(keys[g]),
                .o_press(press[g])
            );
        end
    endgenerate
    // Shift only ever acts as a held modifier, so its edge goes unused
    wire p_view = press[0];
    wire p_pattern = press[1];
    wire p_go = press[2];
    wire p_commit = press[4];
    wire p_erase = press[5];
    wire p_param = press[6];
    wire p_down = press[7];
    wire p_am = press[8];

    // ----------------------------------------
    // Shared blink timer
    // ----------------------------------------
    wire blink;
    wire sweep_step;
    fpcc_blink_timer u_blink (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .o_phase(blink),
        .o_step(sweep_step)
    );

    // ----------------------------------------
    // Console state, mode and selections
    // ----------------------------------------
    reg [4:0] program_no;
    reg [4:0] edit_program;
    reg [2:0] view;
    reg sweeping;
    reg [1:0] sweep_pos;
    wire basic = (o_console_state == `FPCC_ST_BASIC);
    wire in_pattern_key = (o_console_state == `FPCC_ST_PATTERN_KEY);
    wire m_ready = (o_mode == `FPCC_MODE_READY);
    wire m_run = (o_mode == `FPCC_MODE_RUN);
    wire m_hold = (o_mode == `FPCC_MODE_HOLD);
    wire m_fast = (o_mode == `FPCC_MODE_FAST);
    wire m_end = (o_mode == `FPCC_MODE_END);

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_console_state <= `FPCC_ST_BASIC;
            o_mode <= `FPCC_MODE_READY;
            o_manual <= 1'b0;
            o_advance <= 1'b0;
            o_seg_insert_delete <= 1'b0;
            o_item_clear <= 1'b0;
            program_no <= `FPCC_PATTERN_KEY_MIN;
            edit_program <= `FPCC_PATTERN_KEY_MIN;
            view <= `FPCC_VIEW_MEAS;
            sweeping <= 1'b1;
            sweep_pos <= 2'h0;
        end else if (i_ce) begin
            o_advance <= 1'b0;
            o_seg_insert_delete <= 1'b0;
            o_item_clear <= 1'b0;
            if (sweep_step && sweeping) begin
                sweep_pos <= sweep_pos + 2'h1;
                if (sweep_pos == 2'h2) begin
                    sweeping <= 1'b0;
                end
            end
            if (i_program_end && !m_ready) begin
                o_mode <= `FPCC_MODE_END;
            end
            if (p_am) begin
                o_manual <= ~o_manual;
            end
            case (o_console_state)
                `FPCC_ST_BASIC: begin
                    if (i_shift_key && p_param) begin
                        o_console_state <= `FPCC_ST_PARAM;
                    end else if (i_shift_key && p_pattern) begin
                        o_console_state <= `FPCC_ST_PATTERN_KEY;
                        edit_program <= program_no;
                    end else if (i_shift_key && i_erase_key && p_view && m_ready && !o_manual) begin
                        o_console_state <= `FPCC_ST_GRESET;
                    end else if (i_shift_key && p_down) begin
                        if (m_run || m_hold) begin
                            o_mode <= `FPCC_MODE_FAST;
                        end
                    end else if (i_pattern_key && p_go) begin
                        if (m_hold || m_fast || m_end) begin
                            o_mode <= `FPCC_MODE_READY;
                        end
                    end else if (i_pattern_key && p_view) begin
                        if (m_run || m_hold || m_fast) begin
                            o_advance <= 1'b1;
                        end
                    end else if (i_down_key && p_pattern && m_ready) begin
                        o_console_state <= `FPCC_ST_COPY;
                    end else if (p_go) begin
                        if (m_ready || m_hold || m_fast) begin
                            o_mode <= `FPCC_MODE_RUN;
                        end else if (m_run) begin
                            o_mode <= `FPCC_MODE_HOLD;
                        end
                    end else if (p_pattern && m_ready) begin
                        program_no <= (program_no == `FPCC_PATTERN_KEY_MAX) ? `FPCC_PATTERN_KEY_MIN
                                      : program_no + 5'h01;
                    end else if (p_view) begin
                        view <= (view == `FPCC_VIEW_LAST) ? `FPCC_VIEW_MEAS : view + 3'h1;
                    end
                end
                `FPCC_ST_PATTERN_KEY: begin
                    if (i_shift_key && p_pattern) begin
                        edit_program <= (edit_program == `FPCC_PATTERN_KEY_MAX) ? `FPCC_PATTERN_KEY_MIN
                                        : edit_program + 5'h01;
                    end else if (i_shift_key && p_down) begin
                        edit_program <= (edit_program == `FPCC_PATTERN_KEY_MIN) ? `FPCC_PATTERN_KEY_MAX
                                        : edit_program - 5'h01;
                    end else if (i_shift_key && p_commit) begin
                        o_seg_insert_delete <= 1'b1;
                    end else if (i_shift_key && p_erase) begin
                        o_item_clear <= 1'b1;
                    end else if (i_setup_exit) begin
                        o_console_state <= `FPCC_ST_BASIC;
                    end
                end
                `FPCC_ST_PARAM, `FPCC_ST_COPY, `FPCC_ST_GRESET: begin
                    // Exit decided by the setup sequencer, which owns item navigation
                    if (i_setup_exit) begin
                        o_console_state <= `FPCC_ST_BASIC;
                    end
                end
                default: begin
                    o_console_state <= `FPCC_ST_BASIC;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Lamps and displays
    // ----------------------------------------
    reg [`FPCC_PROFILE_W-1:0] trend_bits;
    always @* begin
        case (i_trend)
            2'h0: trend_bits = 3'b001;
            2'h1: trend_bits = 3'b010;
            2'h2: trend_bits = 3'b100;
            default: trend_bits = 3'b000;
        endcase
    end

    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_run_lamp <= 1'b0;
            o_hold_lamp <= 1'b0;
            o_hand_control_lamp <= 1'b0;
            o_programming_lamp <= 1'b0;
            o_low_cell_lamp <= 1'b0;
            o_tuning_lamp <= 1'b0;
            o_drive1_lamp <= 1'b0;
            o_drive2_lamp <= 1'b0;
            o_measured_value_lamp <= 1'b0;
            o_setpoint_lamp <= 1'b0;
            o_output_lamp <= 1'b0;
            o_timer_lamp <= 1'b0;
            o_period_lamp <= 1'b0;
            o_channel_one_lamp <= 1'b0;
            o_channel_two_lamp <= 1'b0;
            o_occurrence_lamps <= 3'h0;
            o_timed_signal_lamps <= 5'h00;
            o_program_display <= `FPCC_BLANK;
            o_segment_display <= `FPCC_BLANK;
            o_profile <= 3'b000;
        end else if (i_ce) begin
            o_run_lamp <= m_run | (m_fast & blink);
            o_hold_lamp <= m_hold | (m_end & blink);
            o_hand_control_lamp <= o_manual;
            o_programming_lamp <= in_pattern_key;
            o_low_cell_lamp <= i_battery_low & blink;
            o_tuning_lamp <= (i_auto_tuning & blink) | (~i_auto_tuning & i_smart_tuning);
            if (i_out1_kind == `FPCC_OUTK_CURRENT) begin
                o_drive1_lamp <= 1'b1;
            end else begin
                o_drive1_lamp <= i_position_prop ? i_open_relay_on : i_out1_on;
            end
            if (i_out2_kind == `FPCC_OUTK_CURRENT) begin
                o_drive2_lamp <= 1'b1;
            end else if (i_out2_kind == `FPCC_OUTK_AUX) begin
                o_drive2_lamp <= 1'b0;
            end else begin
                o_drive2_lamp <= i_position_prop ? i_close_relay_on : i_out2_on;
            end
            o_measured_value_lamp <= (view == `FPCC_VIEW_MEAS);
            o_setpoint_lamp <= (view == `FPCC_VIEW_SETP);
            o_output_lamp <= (view == `FPCC_VIEW_OUT);
            o_timer_lamp <= (view == `FPCC_VIEW_TIME);
            o_period_lamp <= (view == `FPCC_VIEW_CYC);
            o_channel_one_lamp <= 1'b0;
            o_channel_two_lamp <= 1'b0;
            o_occurrence_lamps <= in_pattern_key ? i_event_item_shown : i_events;
            o_timed_signal_lamps <= in_pattern_key ? i_time_item_shown : i_time_events;
            // Alarm and blanking only apply in basic display
            if (in_pattern_key) begin
                o_program_display <= {3'h0, edit_program};
                o_segment_display <= i_edit_segment;
            end else if (o_console_state == `FPCC_ST_PARAM) begin
                o_program_display <= `FPCC_BLANK;
                o_segment_display <= i_item_number;
            end else if (basic && i_alarm) begin
                o_program_display <= `FPCC_ALARM_MARK;
                o_segment_display <= i_alarm_code;
            end else if (basic && i_constant_mode) begin
                o_program_display <= `FPCC_BLANK;
                o_segment_display <= `FPCC_BLANK;
            end else begin
                o_program_display <= {3'h0, program_no};
                o_segment_display <= i_segment;
            end
            if (sweeping) begin
                o_profile <= 3'b001 << sweep_pos;
            end else if (i_soak_standby) begin
                o_profile <= blink ? trend_bits : 3'b000;
            end else begin
                o_profile <= trend_bits;
            end
        end
    end
endmodule // fpcc_console

// ===== core/fpcc_key_edge.v
// Rising-edge detector for one key line.
// Assumes key inputs already debounced and synchronous to the clock.
`timescale 1ns/1ps
module fpcc_key_edge (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_key,
    output wire o_press
);
    reg key_q;
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            key_q <= 1'b0;
        end else if (i_ce) begin
            key_q <= i_key;
        end
    end
    assign o_press = i_ce & i_key & ~key_q;
endmodule // fpcc_key_edge

// ===== core/fpcc_map.vh
// Constants for the front-panel console control block.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef FPCC_MAP_VH
`define FPCC_MAP_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define FPCC_CLK_HZ 25000000
`define FPCC_BLINK_HALF_MS 250
`define FPCC_BLINK_HALF_CYC ((`FPCC_CLK_HZ / 1000) * `FPCC_BLINK_HALF_MS)
`define FPCC_SWEEP_STEP_MS 200
`define FPCC_SWEEP_STEP_CYC ((`FPCC_CLK_HZ / 1000) * `FPCC_SWEEP_STEP_MS)
// ----------------------------------------
// Program modes
// ----------------------------------------
`define FPCC_MODE_READY 3'h0
`define FPCC_MODE_RUN 3'h1
`define FPCC_MODE_HOLD 3'h2
`define FPCC_MODE_FAST 3'h3
`define FPCC_MODE_END 3'h4
// ----------------------------------------
// Console states
// ----------------------------------------
`define FPCC_ST_BASIC 3'h0
`define FPCC_ST_PARAM 3'h1
`define FPCC_ST_PATTERN_KEY 3'h2
`define FPCC_ST_COPY 3'h3
`define FPCC_ST_GRESET 3'h4
// ----------------------------------------
// Display selection codes
// ----------------------------------------
`define FPCC_VIEW_MEAS 3'h0
`define FPCC_VIEW_SETP 3'h1
`define FPCC_VIEW_OUT 3'h2
`define FPCC_VIEW_TIME 3'h3
`define FPCC_VIEW_CYC 3'h4
`define FPCC_VIEW_LAST 3'h4
// ----------------------------------------
// Output kinds and misc
// ----------------------------------------
`define FPCC_OUTK_SWITCHED 2'h0
`define FPCC_OUTK_CURRENT 2'h1
`define FPCC_OUTK_AUX 2'h2
`define FPCC_PATTERN_KEY_MAX 5'h13
`define FPCC_PATTERN_KEY_MIN 5'h01
`define FPCC_ALARM_MARK 8'hAA
`define FPCC_BLANK 8'hFF
`define FPCC_PROFILE_W 3
`endif

// ===== testbench/fpcc_console_props.sv
// Checker for the console block: mode, lamp and key relations.
// Assumes it is bound onto fpcc_console with fpcc_map.vh on the include path.
`timescale 1ns/1ps
`include "fpcc_map.vh"
module fpcc_console_props (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_pattern_key,
    input wire i_go_pause_key,
    input wire i_shift_key,
    input wire i_param_key,
    input wire i_down_key,
    input wire i_auto_manual_key,
    input wire i_program_end,
    input wire i_battery_low,
    input wire [2:0] o_mode,
    input wire [2:0] o_console_state,
    input wire o_manual,
    input wire o_advance,
    input wire o_run_lamp,
    input wire o_hold_lamp,
    input wire o_hand_control_lamp,
    input wire o_programming_lamp,
    input wire o_low_cell_lamp,
    input wire o_measured_value_lamp,
    input wire o_setpoint_lamp,
    input wire o_output_lamp,
    input wire o_timer_lamp,
    input wire o_period_lamp,
    input wire o_channel_one_lamp,
    input wire o_channel_two_lamp
);
    // A held pattern key turns a go press into something else; shift, down and a forced end are excluded as well
    wire mods_up = i_pattern_key || i_shift_key || i_down_key || i_program_end || !i_ce;
    wire in_basic = (o_console_state == `FPCC_ST_BASIC);

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_RESET_STATE: assert property ($rose(i_rstn) |-> in_basic && o_mode == `FPCC_MODE_READY)
        else $error("console not in basic READY after reset");
    AST_RUN_LAMP: assert property (o_mode == `FPCC_MODE_RUN && $stable(o_mode) |-> o_run_lamp && !o_hold_lamp)
        else $error("mode lamps wrong in RUN");
    AST_HOLD_LAMP: assert property (o_mode == `FPCC_MODE_HOLD && $stable(o_mode) |-> !o_run_lamp && o_hold_lamp)
        else $error("mode lamps wrong in HOLD");
    AST_READY_DARK: assert property (o_mode == `FPCC_MODE_READY && $stable(o_mode) |-> !o_run_lamp && !o_hold_lamp)
        else $error("mode lamps lit in READY");
    AST_HAND_LAMP: assert property ($stable(o_manual) |-> o_hand_control_lamp == o_manual)
        else $error("hand-control lamp disagrees with manual mode");
    AST_PRG_LAMP: assert property ($stable(o_console_state) |-> o_programming_lamp == (o_console_state == `FPCC_ST_PATTERN_KEY))
        else $error("programming lamp disagrees with console state");
    AST_CELL_DARK: assert property (!$past(i_battery_low) |-> !o_low_cell_lamp)
        else $error("low-cell lamp lit with good battery");
    AST_ONE_VIEW: assert property ($past(i_rstn) |-> $onehot({o_measured_value_lamp, o_setpoint_lamp, o_output_lamp,
        o_timer_lamp, o_period_lamp}) && !o_channel_one_lamp && !o_channel_two_lamp)
        else $error("indicator lamps not exactly one");
    AST_GO_READY: assert property ($rose(i_go_pause_key) && !mods_up && in_basic && o_mode == `FPCC_MODE_READY
        |=> o_mode == `FPCC_MODE_RUN)
        else $error("go key did not start from READY");
    AST_GO_RUN: assert property ($rose(i_go_pause_key) && !mods_up && in_basic && o_mode == `FPCC_MODE_RUN
        |=> o_mode == `FPCC_MODE_HOLD)
        else $error("go key did not hold from RUN");
    // Mode may move to END on the pulse edge, so judge the mode it was decided in
    AST_ADVANCE: assert property (o_advance |-> $past(o_mode) inside {`FPCC_MODE_RUN, `FPCC_MODE_HOLD, `FPCC_MODE_FAST}
        ##1 !o_advance)
        else $error("advance pulse in wrong mode or too long");
    AST_FAST_ENTRY: assert property (o_mode == `FPCC_MODE_FAST && $past(o_mode) != `FPCC_MODE_FAST
        |-> $past(o_mode) inside {`FPCC_MODE_RUN, `FPCC_MODE_HOLD})
        else $error("FAST entered from an illegal mode");
    AST_MANUAL_TOGGLE: assert property ($rose(i_auto_manual_key) && i_ce |=> o_manual != $past(o_manual))
        else $error("auto/manual key did not toggle");
    AST_PATTERN_KEY_ENTRY: assert property ($rose(i_pattern_key) && i_shift_key && !i_param_key && i_ce && in_basic
        |=> o_console_state == `FPCC_ST_PATTERN_KEY)
        else $error("shift with pattern did not open program setup");
endmodule // fpcc_console_props

bind fpcc_console fpcc_console_props u_props (.*);

// ===== testbench/fpcc_console_tb.sv
// Self-checking bench for the console block, keys driven by the operator model.
// Assumes fpcc_map.vh on the include path and the checker bound in.
`timescale 1ns/1ps
`include "fpcc_map.vh"
module fpcc_console_tb;
    localparam logic [8:0] K_VIEW = 9'h001, K_PAT = 9'h002, K_GO = 9'h004, K_SHIFT = 9'h008, K_COMMIT = 9'h010;
    localparam logic [8:0] K_ERASE = 9'h020, K_PARAM = 9'h040, K_DOWN = 9'h080, K_AM = 9'h100;
    logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, i_program_end = 1'b0, i_constant_mode = 1'b0;
    logic i_alarm = 1'b0, i_battery_low = 1'b0, i_auto_tuning = 1'b0, i_smart_tuning = 1'b0, i_position_prop = 1'b0;
    logic i_out1_on = 1'b0, i_out2_on = 1'b0, i_open_relay_on = 1'b0, i_close_relay_on = 1'b0;
    logic i_soak_standby = 1'b0, i_setup_exit = 1'b0;
    logic [7:0] i_alarm_code = 8'h00, i_segment = 8'h05, i_item_number = 8'h00, i_edit_segment = 8'h00;
    logic [1:0] i_out1_kind = 2'h0, i_out2_kind = 2'h0, i_trend = 2'h3;
    logic [2:0] i_events = 3'h0, i_event_item_shown = 3'h0;
    logic [4:0] i_time_events = 5'h00, i_time_item_shown = 5'h00;
    wire [8:0] keys;
    wire i_view_key, i_pattern_key, i_go_pause_key, i_shift_key, i_commit_key, i_erase_key;
    wire i_param_key, i_down_key, i_auto_manual_key;
    wire [2:0] o_mode, o_console_state, o_occurrence_lamps;
    wire [4:0] o_timed_signal_lamps;
    wire [7:0] o_program_display, o_segment_display;
    wire [`FPCC_PROFILE_W-1:0] o_profile;
    wire o_manual, o_advance, o_seg_insert_delete, o_item_clear, o_run_lamp, o_hold_lamp, o_hand_control_lamp;
    wire o_programming_lamp, o_low_cell_lamp, o_tuning_lamp, o_drive1_lamp, o_drive2_lamp, o_measured_value_lamp;
    wire o_setpoint_lamp, o_output_lamp, o_timer_lamp, o_period_lamp, o_channel_one_lamp, o_channel_two_lamp;
    wire [4:0] views = {o_measured_value_lamp, o_setpoint_lamp, o_output_lamp, o_timer_lamp, o_period_lamp};
    int error_cnt = 0, compares = 0, cycles = 0, adv_n = 0, sid_n = 0, clr_n = 0;

    assign {i_auto_manual_key, i_down_key, i_param_key, i_erase_key, i_commit_key} = keys[8:4];
    assign {i_shift_key, i_go_pause_key, i_pattern_key, i_view_key} = keys[3:0];

    fpcc_operator op (.i_sys_clk(i_sys_clk), .o_keys(keys));
    fpcc_console DUT (.*);

    always #20 i_sys_clk = ~i_sys_clk;

    // Pulses are one cycle long, so count them where they are settled
    always @(negedge i_sys_clk) begin
        if (o_advance === 1'b1) adv_n++;
        if (o_seg_insert_delete === 1'b1) sid_n++;
        if (o_item_clear === 1'b1) clr_n++;
    end

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up;
        $display("Compares: %0d, mismatches: %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    task automatic key_mode(input logic [8:0] hold, input logic [8:0] hit, input logic [2:0] m);
        op.press(hold, hit, 1);
        check(o_mode, m);
    endtask

    task automatic exit_setup;
        i_setup_exit = 1'b1;
        tick(1);
        i_setup_exit = 1'b0;
        tick(2);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        tick(16);
        i_rstn = 1'b1;
        tick(3);
        check(o_console_state, `FPCC_ST_BASIC);
        check(o_mode, `FPCC_MODE_READY);
        check(o_program_display, 8'h01);
        check(o_segment_display, 8'h05);
        check(o_profile, 3'h1);
        for (int i = 2; i <= 20; i++) begin
            op.press(9'h000, K_PAT, 0);
            check(o_program_display, (i > 19) ? 8'h01 : 8'(i));
        end
        for (int i = 1; i <= 5; i++) begin
            op.press(9'h000, K_VIEW, 0);
            check(views, 5'h10 >> (i % 5));
        end
        check({o_channel_one_lamp, o_channel_two_lamp}, 2'h0);
        key_mode(9'h000, K_GO, `FPCC_MODE_RUN);
        check({o_run_lamp, o_hold_lamp}, 2'h2);
        key_mode(9'h000, K_GO, `FPCC_MODE_HOLD);
        check({o_run_lamp, o_hold_lamp}, 2'h1);
        key_mode(K_SHIFT, K_DOWN, `FPCC_MODE_FAST);
        key_mode(9'h000, K_GO, `FPCC_MODE_RUN);
        key_mode(K_PAT, K_VIEW, `FPCC_MODE_RUN);
        key_mode(K_SHIFT, K_DOWN, `FPCC_MODE_FAST);
        key_mode(K_PAT, K_VIEW, `FPCC_MODE_FAST);
        key_mode(K_PAT, K_GO, `FPCC_MODE_READY);
        key_mode(K_PAT, K_GO, `FPCC_MODE_READY);
        key_mode(K_SHIFT, K_DOWN, `FPCC_MODE_READY);
        key_mode(K_PAT, K_VIEW, `FPCC_MODE_READY);
        check(8'(adv_n), 8'h02);
        check({o_run_lamp, o_hold_lamp}, 2'h0);
        key_mode(9'h000, K_GO, `FPCC_MODE_RUN);
        i_program_end = 1'b1;
        tick(2);
        check(o_mode, `FPCC_MODE_END);
        i_program_end = 1'b0;
        key_mode(K_PAT, K_GO, `FPCC_MODE_READY);
        op.press(9'h000, K_AM, 0);
        check({o_manual, o_hand_control_lamp}, 2'h3);
        op.press(9'h000, K_AM, 0);
        check({o_manual, o_hand_control_lamp}, 2'h0);
        i_alarm = 1'b1;
        i_alarm_code = 8'h21;
        tick(2);
        check(o_program_display, `FPCC_ALARM_MARK);
        check(o_segment_display, 8'h21);
        i_alarm = 1'b0;
        i_constant_mode = 1'b1;
        i_battery_low = 1'b1;
        tick(2);
        check(o_program_display, `FPCC_BLANK);
        check(o_segment_display, `FPCC_BLANK);
        i_constant_mode = 1'b0;
        i_battery_low = 1'b0;
        i_smart_tuning = 1'b1;
        i_out1_kind = `FPCC_OUTK_CURRENT;
        i_out2_kind = `FPCC_OUTK_AUX;
        i_out2_on = 1'b1;
        tick(2);
        check({o_low_cell_lamp, o_tuning_lamp, o_drive1_lamp, o_drive2_lamp}, 4'h6);
        i_out1_kind = `FPCC_OUTK_SWITCHED;
        i_out2_kind = `FPCC_OUTK_CURRENT;
        tick(2);
        check({o_drive1_lamp, o_drive2_lamp}, 2'h1);
        i_out2_kind = `FPCC_OUTK_SWITCHED;
        i_position_prop = 1'b1;
        i_open_relay_on = 1'b1;
        i_events = 3'h5;
        i_time_events = 5'h12;
        i_event_item_shown = 3'h2;
        i_time_item_shown = 5'h01;
        i_item_number = 8'h07;
        i_edit_segment = 8'h09;
        tick(2);
        check({o_drive1_lamp, o_drive2_lamp}, 2'h2);
        check(o_occurrence_lamps, 3'h5);
        check(o_timed_signal_lamps, 5'h12);
        op.press(K_SHIFT, K_PARAM, 1);
        check(o_console_state, `FPCC_ST_PARAM);
        check(o_segment_display, 8'h07);
        check(o_occurrence_lamps, 3'h5);
        exit_setup();
        check(o_console_state, `FPCC_ST_BASIC);
        op.press(K_SHIFT, K_PAT, 1);
        check({o_console_state, o_programming_lamp}, 8'h05);
        check(o_program_display, 8'h03);
        check(o_segment_display, 8'h09);
        check(o_occurrence_lamps, 3'h2);
        check(o_timed_signal_lamps, 5'h01);
        op.press(K_SHIFT, K_PAT, 1);
        check(o_program_display, 8'h04);
        op.press(K_SHIFT, K_DOWN, 1);
        check(o_program_display, 8'h03);
        op.press(K_SHIFT, K_COMMIT, 1);
        op.press(K_SHIFT, K_ERASE, 1);
        check(8'(sid_n * 16 + clr_n), 8'h11);
        exit_setup();
        check({o_console_state, o_programming_lamp}, 8'h00);
        wrap_up();
    end
endmodule // fpcc_console_tb

// ===== testbench/fpcc_operator.sv
// Operator model: strikes console keys, alone or under held modifiers.
// Assumes keys are sampled on the rising edge; it moves them on the falling one.
`timescale 1ns/1ps
module fpcc_operator (
    input wire i_sys_clk,
    output logic [8:0] o_keys
);
    initial o_keys = 9'h000;

    // Modifiers go down dwell+1 cycles early; all keys stay up one extra
    // edge afterwards, since the key detectors need a low sample between presses
    task automatic press(input logic [8:0] hold, input logic [8:0] hit, input int dwell);
        @(negedge i_sys_clk);
        if (hold !== 9'h000) begin
            o_keys = hold;
            repeat (dwell + 1) @(negedge i_sys_clk);
        end
        o_keys = hold | hit;
        @(negedge i_sys_clk);
        o_keys = 9'h000;
        @(negedge i_sys_clk);
    endtask
endmodule // fpcc_operator
